// ===== rtl/pfm_top.sv
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "pfm_consts.svh"
// Functional notes
// - each pin offers one to four functions, and single-function pins get no select field.
// - reset clears every select field so each pin runs in its function 0 role.
// - field values 0 to 3 route the pin to functions 0 to 3 as listed for that pin.
// - every select register is 8 bits wide and holds up to four 2-bit fields.
// - the port 0 register holds bit n's field at bits 2n+1:2n, 1 for analog input n, 0 for port.
// - port 0 fields are read/write, reset to 0, with codes 10 and 11 reserved.
// - the port 1 low register selects serial channel 0 pins and slave selects on bits 7:6.
// - the port 1 high register routes bits 4 to 6 to serial channel 1 data in, out and clock.
// - the port 2 high register uses value 2 for i2c target bus-free request, data and clock.
// - the port 3 low register selects timer output, bus-free/inverted timer/trigger, watchdog/clock.
// - the port 3 high register keeps debug roles at 0 and gives port 3 bits 5 to 7 at 1.
// - the port 4 low register selects uart, i2c target data, event counter, remote and pwm input.
// - the port 4 bit 4 register selects i2c target clock at 1 or remote transmit at 2.
// - the port 5 register selects i2c controller, remote, event counter and inverted timer.
module pfm_top
  import pfm_pkg::*;
(
  input  wire logic                  clk_i,      // system clock, 125 MHz
  input  wire logic                  rst_i,      // synchronous reset, active high
  input  wire logic                  wb_cyc_i,   // wishbone cycle
  input  wire logic                  wb_stb_i,   // wishbone strobe
  input  wire logic                  wb_we_i,    // wishbone write enable
  input  wire pfm_pkg::pfm_adr_t     wb_adr_i,   // wishbone byte address
  input  wire pfm_pkg::pfm_byte_en_t wb_sel_i,   // wishbone byte lanes
  input  wire pfm_pkg::pfm_word_t    wb_dat_i,   // wishbone write data
  output logic [31:0]                wb_dat_o,   // wishbone read data
  output logic                       wb_ack_o,   // wishbone acknowledge
  input  wire pfm_pkg::pfm_fn_vec_t  fn_out_i,   // per slot and function: drive level
  input  wire pfm_pkg::pfm_fn_vec_t  fn_oe_n_i,  // per slot and function: drive enable, low
  input  wire pfm_pkg::pfm_pin_vec_t pad_in_i,   // per slot: level seen on the pad
  output logic [35:0]                pad_out_o,  // per slot: level driven to the pad
  output logic [35:0]                pad_oe_n_o, // per slot: pad output enable, low
  output logic [143:0]               fn_in_o     // per slot and function: pad level routed in
);
  import pfm_pkg::*;

  pfm_reg_t    sel_q [`PFM_NUM_REGS];
  logic        ack_q;
  pfm_word_t   rdat_q;
  pfm_pin_vec_t  pad_out_q;
  pfm_pin_vec_t  pad_oe_n_q;
  pfm_fn_vec_t   fn_in_q;

  // register index from word address; 4'hf when unmapped
  function automatic logic [3:0] reg_index(input logic [15:0] idx);
    case (idx)
      `PFM_IDX_PORT0:      reg_index = 4'h0;
      `PFM_IDX_PORT1_LOW:  reg_index = 4'h1;
      `PFM_IDX_PORT1_HIGH: reg_index = 4'h2;
      `PFM_IDX_PORT2_HIGH: reg_index = 4'h3;
      `PFM_IDX_PORT3_LOW:  reg_index = 4'h4;
      `PFM_IDX_PORT3_HIGH: reg_index = 4'h5;
      `PFM_IDX_PORT4_LOW:  reg_index = 4'h6;
      `PFM_IDX_PORT4_BIT4: reg_index = 4'h7;
      `PFM_IDX_PORT5:      reg_index = 4'h8;
      default:             reg_index = 4'hf;
    endcase
  endfunction

  // which functions exist on each field of a register
  function automatic logic [15:0] avail(input int r);
    case (r)
      0:       avail = `PFM_AVAIL_PORT0;
      1:       avail = `PFM_AVAIL_PORT1_LOW;
      2:       avail = `PFM_AVAIL_PORT1_HIGH;
      3:       avail = `PFM_AVAIL_PORT2_HIGH;
      4:       avail = `PFM_AVAIL_PORT3_LOW;
      5:       avail = `PFM_AVAIL_PORT3_HIGH;
      6:       avail = `PFM_AVAIL_PORT4_LOW;
      7:       avail = `PFM_AVAIL_PORT4_BIT4;
      8:       avail = `PFM_AVAIL_PORT5;
      default: avail = 16'h1111;
    endcase
  endfunction

  // fields without any function beyond 0 are reserved bits: not stored, read as 0
  function automatic pfm_reg_t field_mask(input logic [15:0] av);
    pfm_reg_t m;
    m = 8'h00;
    for (int j = 0; j < `PFM_FIELDS_PER_REG; j++)
    begin
      if (av[4*j+1 +: 3] != 3'h0)
      begin
        m[2*j +: 2] = 2'h3;
      end
    end
    field_mask = m;
  endfunction

  // a code naming no function on this pin falls back to function 0
  function automatic pfm_sel_t effective_sel(input pfm_sel_t code, input logic [3:0] av);
    effective_sel = av[code] ? code : `PFM_FIELD_FN0;
  endfunction

  wire logic [3:0] hit_idx  = reg_index(wb_adr_i[17:2]);
  wire logic       hit      = (hit_idx != 4'hf);
  wire logic       req      = wb_cyc_i && wb_stb_i;
  // write lands on the edge where the master sees ack, matching the classic handshake
  wire logic       wr_fire  = req && ack_q && wb_we_i && wb_sel_i[0] && hit;

  // wishbone slave: one wait state, unmapped addresses ack with zero data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= req && !ack_q;
      rdat_q <= (req && !ack_q && hit) ? {24'h00_0000, sel_q[hit_idx[3:0]]} : 32'h0000_0000;
    end
  end

  genvar r;
  genvar j;
  generate
    for (r = 0; r < `PFM_NUM_REGS; r++)
    begin : g_reg
      localparam logic [15:0] AV = avail(r);
      localparam pfm_reg_t    WM = field_mask(AV);
      wire logic              wr_this = wr_fire && (hit_idx == 4'(r));

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sel_q[r] <= `PFM_REG_RESET;
        end
        else if (wr_this)
        begin
          sel_q[r] <= wb_dat_i[7:0] & WM;
        end
      end

      for (j = 0; j < `PFM_FIELDS_PER_REG; j++)
      begin : g_pin
        localparam int K = r * `PFM_FIELDS_PER_REG + j;
        wire logic [3:0] av_pin = AV[4*j +: 4];
        wire pfm_sel_t   eff    = effective_sel(sel_q[r][2*j +: 2], av_pin);

        always_ff @(posedge clk_i)
        begin
          if (rst_i)
          begin
            pad_out_q[K]  <= 1'b0;
            pad_oe_n_q[K] <= 1'b1;
          end
          else
          begin
            pad_out_q[K]  <= fn_out_i[4*K + eff];
            pad_oe_n_q[K] <= fn_oe_n_i[4*K + eff];
          end
        end

        for (genvar f = 0; f < `PFM_NUM_FN; f++)
        begin : g_fn
          // unselected functions see a steady 0 rather than the pad
          always_ff @(posedge clk_i)
          begin
            if (rst_i)
            begin
              fn_in_q[4*K + f] <= 1'b0;
            end
            else
            begin
              fn_in_q[4*K + f] <= (eff == 2'(f)) ? pad_in_i[K] : 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  assign wb_ack_o   = ack_q;
  assign wb_dat_o   = rdat_q;
  assign pad_out_o  = pad_out_q;
  assign pad_oe_n_o = pad_oe_n_q;
  assign fn_in_o    = fn_in_q;

endmodule // pfm_top

// ===== rtl/pfm_consts.svh
`ifndef PFM_CONSTS_SVH
`define PFM_CONSTS_SVH

// register indices; the byte address on the bus is four times the index
`define PFM_IDX_PORT0        16'h4420
`define PFM_IDX_PORT1_LOW    16'h4422
`define PFM_IDX_PORT1_HIGH   16'h4423
`define PFM_IDX_PORT2_HIGH   16'h4425
`define PFM_IDX_PORT3_LOW    16'h4426
`define PFM_IDX_PORT3_HIGH   16'h4427
`define PFM_IDX_PORT4_LOW    16'h4428
`define PFM_IDX_PORT4_BIT4   16'h4429
`define PFM_IDX_PORT5        16'h442a

// sizes
`define PFM_NUM_REGS         9
`define PFM_FIELDS_PER_REG   4
`define PFM_FIELD_W          2
`define PFM_NUM_FN           4
`define PFM_NUM_SLOTS        36

// reset value of every select register (all fields at function 0)
`define PFM_REG_RESET        8'h00
`define PFM_FIELD_FN0        2'h0

// per register, 4 bits per field: bit f set when function f exists on that pin
`define PFM_AVAIL_PORT0      16'h3333
`define PFM_AVAIL_PORT1_LOW  16'hf333
`define PFM_AVAIL_PORT1_HIGH 16'h1333
`define PFM_AVAIL_PORT2_HIGH 16'h5551
`define PFM_AVAIL_PORT3_LOW  16'h1ff3
`define PFM_AVAIL_PORT3_HIGH 16'h3331
`define PFM_AVAIL_PORT4_LOW  16'hf733
`define PFM_AVAIL_PORT4_BIT4 16'h1117
`define PFM_AVAIL_PORT5      16'h3777

`endif

// ===== rtl/pfm_pkg.sv
package pfm_pkg;
  typedef logic [7:0]   pfm_reg_t;
  typedef logic [1:0]   pfm_sel_t;
  typedef logic [35:0]  pfm_pin_vec_t;
  typedef logic [143:0] pfm_fn_vec_t;
  typedef logic [17:0]  pfm_adr_t;
  typedef logic [31:0]  pfm_word_t;
  typedef logic [3:0]   pfm_byte_en_t;
  typedef enum logic [1:0]
  {
    PFM_FN0 = 2'b00,
    PFM_FN1 = 2'b01,
    PFM_FN2 = 2'b10,
    PFM_FN3 = 2'b11
  } pfm_fn_t;
endpackage

// ===== sim/pfm_top_sva.sv
`timescale 1ns/1ps
module pfm_top_sva
  import pfm_pkg::*;
(
  input wire logic                  clk_i,      // clock
  input wire logic                  rst_i,      // reset
  input wire logic                  wb_cyc_i,   // cycle
  input wire logic                  wb_stb_i,   // strobe
  input wire logic [31:0]           wb_dat_o,   // read data
  input wire logic                  wb_ack_o,   // ack
  input wire pfm_pkg::pfm_fn_vec_t  fn_out_i,   // fn levels
  input wire pfm_pkg::pfm_fn_vec_t  fn_oe_n_i,  // fn enables
  input wire pfm_pkg::pfm_pin_vec_t pad_in_i,   // pad levels
  input wire logic [35:0]           pad_out_o,  // pad drive
  input wire logic [35:0]           pad_oe_n_o, // pad enable
  input wire logic [143:0]          fn_in_o     // routed in
);
  logic [143:0] pin4_q;
  always_ff @(posedge clk_i)
    for (int k = 0; k < 36; k++) pin4_q[4*k +: 4] <= {4{pad_in_i[k]}};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_after_req: assert property (s_req |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_dat_narrow: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data wider than 8 bits");
  a_reset_state: assert property ($fell(rst_i) |-> &pad_oe_n_o && fn_in_o == '0)
    else $error("outputs not cleared by reset");
  // slot 29 has no select field, so it stays on function 0
  a_fixed_slot: assert property (!$past(rst_i) |-> pad_out_o[29] == $past(fn_out_i[116])
    && pad_oe_n_o[29] == $past(fn_oe_n_i[116]) && fn_in_o[119:117] == 3'h0)
    else $error("fixed pin left function 0");
  a_fn_in_gated: assert property ((fn_in_o & ~pin4_q) == '0)
    else $error("routed input not from its pad");
endmodule // pfm_top_sva

// ===== sim/pfm_far_end.sv
`timescale 1ns/1ps
module pfm_far_end
  import pfm_pkg::*;
(
  input  wire logic             clk_i,     // clock
  input  wire logic             rst_i,     // reset
  output pfm_pkg::pfm_fn_vec_t  fn_out_o,  // peripheral levels
  output pfm_pkg::pfm_fn_vec_t  fn_oe_n_o, // peripheral enables, low
  output pfm_pkg::pfm_pin_vec_t pad_in_o   // pad levels
);
  pfm_fn_vec_t  fn_q;
  pfm_pin_vec_t pad_q;
  // one hot per slot, moving every cycle, so a wrong pick shows within four cycles
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      fn_q  <= {36{4'h1}};
      pad_q <= {9{4'h5}};
    end
    else
    begin
      fn_q  <= {fn_q[142:0], fn_q[143]};
      pad_q <= {pad_q[34:0], pad_q[35]};
    end
  assign fn_out_o  = fn_q;
  assign fn_oe_n_o = {fn_q[1:0], fn_q[143:2]};
  assign pad_in_o  = pad_q;
endmodule // pfm_far_end

// ===== sim/test_pfm_top.sv
`timescale 1ns/1ps
module test_pfm_top;
  import pfm_pkg::*;
  logic         clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  pfm_adr_t     wb_adr_i = '0;
  pfm_byte_en_t wb_sel_i = '0;
  pfm_word_t    wb_dat_i = '0;
  logic [31:0]  wb_dat_o;
  logic         wb_ack_o;
  pfm_fn_vec_t  fn_out_i, fn_oe_n_i, fn_in_o;
  pfm_pin_vec_t pad_in_i;
  logic [35:0]  pad_out_o, pad_oe_n_o;
  int           miscompares = 0, n_compared = 0;
  // nibble per field, bit f set where function f exists
  localparam logic [15:0] avail [9] = '{16'h3333, 16'hf333, 16'h1333, 16'h5551,
    16'h1ff3, 16'h3331, 16'hf733, 16'h1117, 16'h3777};
  localparam int ofs [9] = '{0, 2, 3, 5, 6, 7, 8, 9, 10};
  pfm_top     i_pfm_top (.*);
  pfm_far_end i_pfm_far_end (.clk_i, .rst_i, .fn_out_o(fn_out_i), .fn_oe_n_o(fn_oe_n_i),
    .pad_in_o(pad_in_i));
  initial
    forever #4 clk_i = ~clk_i;
  function automatic logic [17:0] adr(input int r);
    return 18'h11080 + 18'(4 * ofs[r]);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [17:0] a, input logic [3:0] sel,
                    input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, we, a, sel};
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic check_slot(input int k, input int f);
    logic v, o, p;
    repeat (4)
    begin
      @(negedge clk_i);
      {v, o, p} = {fn_out_i[4*k+f], fn_oe_n_i[4*k+f], pad_in_i[k]};
      @(negedge clk_i);
      check("slot", {pad_out_o[k], pad_oe_n_o[k], fn_in_o[4*k +: 4]}, {v, o, 4'(p) << f});
    end
  endtask
  task automatic t_reset;
    logic [31:0] q;
    for (int r = 0; r < 9; r++)
    begin
      wb(1'b0, adr(r), 4'h1, 8'h0, q);
      check("reset value", q, 32'h0);
    end
    for (int k = 0; k < 36; k++) check_slot(k, 0);
    $display("reset test done");
  endtask
  task automatic t_codes;
    logic [31:0] q;
    logic [7:0]  w;
    for (int c = 0; c < 4; c++)
    begin
      for (int r = 0; r < 9; r++)
      begin
        for (int j = 0; j < 4; j++) w[2*j +: 2] = (avail[r][4*j+1 +: 3] != 3'h0) ? 2'(c) : 2'h0;
        wb(1'b1, adr(r), 4'h1, w, q);
        wb(1'b0, adr(r), 4'h1, 8'h0, q);
        check("readback", q, {24'h0, w});
      end
      for (int k = 0; k < 36; k++) check_slot(k, avail[k/4][4*(k%4)+c] ? c : 0);
    end
    $display("code test done");
  endtask
  task automatic t_refuse;
    logic [31:0] q;
    wb(1'b1, 18'h11084, 4'h1, 8'h55, q);
    wb(1'b0, 18'h11084, 4'h1, 8'h0, q);
    check("unmapped", q, 32'h0);
    wb(1'b1, adr(0), 4'he, 8'h00, q);
    wb(1'b0, adr(0), 4'h1, 8'h0, q);
    check("lane off", q, 32'hff);
    $display("refusal test done");
  endtask
  task automatic close_out;
    $display("compared %0d wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_codes();
    t_refuse();
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    close_out();
  end
endmodule // test_pfm_top
bind pfm_top pfm_top_sva i_pfm_top_sva (.*);
